// >>> common/pre_pkg.sv
// Purpose: Constants and types for the profile record packet encoder
// Assumes: One byte per handshake toward the buffer write logic
// Notes: Shared by the encoder and its bench
package pre_pkg;
   // Header codes
   localparam logic [7:0] PRE_HDR_PAD = 8'h00;
   localparam logic [7:0] PRE_HDR_END = 8'h01;
   localparam logic [7:0] PRE_HDR_TS = 8'h71;
   localparam logic [4:0] PRE_HDR_ADDR_TOP = 5'h16;
   localparam logic [5:0] PRE_HDR_PFX_TOP = 6'h08;
   // Address indices
   localparam logic [4:0] PRE_IDX_PC = 5'h00;
   localparam logic [4:0] PRE_IDX_TGT = 5'h01;
   localparam logic [4:0] PRE_IDX_DVA = 5'h02;
   localparam logic [4:0] PRE_IDX_DPA = 5'h03;
   // Packet steps and payload length
   localparam logic [2:0] PRE_STEP_TERM = 3'h5;
   localparam logic [2:0] PRE_PAY_LAST = 3'h7;
   localparam logic [2:0] PRE_CNT_RST = 3'h0;
   localparam logic [2:0] PRE_STEP_RST = 3'h0;
   // Record alignment in bytes and FIFO depth
   localparam int PRE_REC_ALIGN = 64;
   localparam int PRE_FIFO_DEPTH = 4;

   typedef enum logic [1:0] {PRE_OP_OTHER, PRE_OP_BRANCH, PRE_OP_ERET, PRE_OP_MEM} pre_op_e;

   typedef enum logic [2:0] {
      PRE_S_IDLE, PRE_S_SEL, PRE_S_PFX, PRE_S_HDR, PRE_S_PAY, PRE_S_TERM, PRE_S_TSPAY, PRE_S_PAD
   } pre_state_e;

   // One sampled operation
   typedef struct packed {
      pre_op_e op;
      logic [55:0] pc;
      logic pc_security_state_bit;
      logic [1:0] pc_privilege_level_field;
      logic [55:0] tgt;
      logic tgt_security_state_bit;
      logic [1:0] tgt_privilege_level_field;
      logic tgt_profiling_off;
      logic [63:0] data_va;
      logic [55:0] data_pa;
      logic pa_security_state_bit;
      logic physical_address_collection_enable;
      logic abort;
      logic perm_fault;
      logic impl_valid;
      logic [4:0] impl_idx;
      logic [63:0] impl_addr;
      logic ts_valid;
      logic [63:0] ts;
   } pre_rec_t;

   // Indices outside defined and implementation ranges are never sent
   function automatic logic pre_idx_ok(input logic [4:0] idx);
      pre_idx_ok = (idx[4:2] == 3'h0) || (idx[4:1] == 4'h3) || idx[4];
   endfunction : pre_idx_ok
endpackage : pre_pkg

// >>> verilog/pre_fifo.sv
// Purpose: Small byte FIFO between packet generator and output stage
// Assumes: Single clock, depth a power of two
// Notes: Full and empty derived from wrap bit of pointers
`timescale 1ns/100ps
module pre_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wptr;
      logic [AW:0] rptr;
   } pre_fifo_st_t;

   pre_fifo_st_t st;
   pre_fifo_st_t next_st;
   logic full;
   logic empty;

   // Status and drain data
   assign full = (st.wptr[AW-1:0] == st.rptr[AW-1:0]) && (st.wptr[AW] != st.rptr[AW]);
   assign empty = (st.wptr == st.rptr);
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = st.mem[st.rptr[AW-1:0]];

   // Pointer and storage update
   always_comb begin
      next_st = st;
      if (in_valid && !full) begin
         next_st.mem[st.wptr[AW-1:0]] = in_data;
         next_st.wptr = st.wptr + 1'b1;
      end
      if (out_ready && !empty) begin
         next_st.rptr = st.rptr + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : pre_fifo

// >>> verilog/pre_encoder.sv
// Purpose: Encodes one sample record per request into a packet byte stream
// Assumes: Record fields stable while rec_valid and rec_ready are both high
// Notes: Records are padded with padding headers to the record alignment
`timescale 1ns/100ps
module pre_encoder
   import pre_pkg::*;
#(
   parameter int REC_ALIGN = PRE_REC_ALIGN,
   parameter int FIFO_DEPTH = PRE_FIFO_DEPTH,
   parameter bit TGT_ON_ERET_OFF = 1'b1,
   parameter bit PA_ON_PERM_FAULT = 1'b0
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Record request
   input wire logic rec_valid,
   input wire pre_rec_t rec,
   output logic rec_ready,
   // Byte stream to buffer write logic
   output logic out_valid,
   output logic [7:0] out_data,
   input wire logic out_ready
);
   localparam int PW = $clog2(REC_ALIGN);

   typedef struct packed {
      pre_state_e state;
      logic [2:0] step;
      logic [2:0] cnt;
      logic [PW-1:0] pos;
      pre_rec_t rec;
      logic rec_ready;
      logic out_valid;
      logic [7:0] out_data;
   } pre_enc_st_t;

   pre_enc_st_t st;
   pre_enc_st_t next_st;
   logic [4:0] incl;
   logic [4:0] cur_idx;
   logic [63:0] cur_pay;
   logic gen_valid;
   logic [7:0] gen_byte;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic fifo_out_ready;
   logic emit;
   logic accept;

   ////////////////////////////////////////////////////////////////////////////
   // Packet selection

   // Which address packets this record carries
   always_comb begin
      incl[0] = 1'b1;
      incl[1] = (st.rec.op == PRE_OP_BRANCH) ||
                ((st.rec.op == PRE_OP_ERET) &&
                 (!st.rec.tgt_profiling_off || TGT_ON_ERET_OFF));
      incl[2] = (st.rec.op == PRE_OP_MEM);
      incl[3] = (st.rec.op == PRE_OP_MEM) && st.rec.physical_address_collection_enable &&
                (!st.rec.abort || (st.rec.perm_fault && PA_ON_PERM_FAULT));
      incl[4] = st.rec.impl_valid && pre_idx_ok(st.rec.impl_idx) &&
                (st.rec.impl_idx[4:2] != 3'h0);
   end

   // Index and 64-bit payload of the current address packet
   always_comb begin
      cur_idx = PRE_IDX_PC;
      cur_pay = {st.rec.pc_security_state_bit, st.rec.pc_privilege_level_field, 5'h00,
                 st.rec.pc};
      case (st.step)
         3'h1: begin
            cur_idx = PRE_IDX_TGT;
            cur_pay = {st.rec.tgt_security_state_bit, st.rec.tgt_privilege_level_field, 5'h00,
                       st.rec.tgt};
         end
         3'h2: begin
            cur_idx = PRE_IDX_DVA;
            cur_pay = st.rec.data_va;
         end
         3'h3: begin
            cur_idx = PRE_IDX_DPA;
            cur_pay = {st.rec.pa_security_state_bit, 7'h00, st.rec.data_pa};
         end
         3'h4: begin
            cur_idx = st.rec.impl_idx;
            cur_pay = st.rec.impl_addr;
         end
         default: begin
            cur_idx = PRE_IDX_PC;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte generation

   // Byte offered to the FIFO in each state
   always_comb begin
      gen_valid = 1'b0;
      gen_byte = PRE_HDR_PAD;
      case (st.state)
         PRE_S_PFX: begin
            gen_valid = 1'b1;
            gen_byte = {PRE_HDR_PFX_TOP, cur_idx[4:3]};
         end
         PRE_S_HDR: begin
            gen_valid = 1'b1;
            gen_byte = {PRE_HDR_ADDR_TOP, cur_idx[2:0]};
         end
         PRE_S_PAY: begin
            gen_valid = 1'b1;
            gen_byte = cur_pay[{st.cnt, 3'h0} +: 8];
         end
         PRE_S_TERM: begin
            gen_valid = 1'b1;
            gen_byte = st.rec.ts_valid ? PRE_HDR_TS : PRE_HDR_END;
         end
         PRE_S_TSPAY: begin
            gen_valid = 1'b1;
            gen_byte = st.rec.ts[{st.cnt, 3'h0} +: 8];
         end
         PRE_S_PAD: begin
            gen_valid = (st.pos != '0);
            gen_byte = PRE_HDR_PAD;
         end
         default: begin
            gen_valid = 1'b0;
         end
      endcase
   end

   // Handshakes toward the FIFO and the record port
   assign emit = gen_valid && fifo_in_ready;
   assign accept = rec_valid && st.rec_ready;
   assign fifo_out_ready = !st.out_valid || out_ready;

   // Byte FIFO between generator and output register
   pre_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(gen_valid),
      .in_data(gen_byte),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   // Next state of the record sequencer and output stage
   always_comb begin
      next_st = st;
      if (emit) begin
         next_st.pos = st.pos + 1'b1;
      end
      case (st.state)
         PRE_S_IDLE: begin
            if (accept) begin
               next_st.rec = rec;
               next_st.step = PRE_STEP_RST;
               next_st.state = PRE_S_SEL;
            end
         end
         PRE_S_SEL: begin
            if (st.step == PRE_STEP_TERM) begin
               next_st.state = PRE_S_TERM;
            end else if (incl[st.step]) begin
               next_st.state = (cur_idx[4:3] == 2'h0) ? PRE_S_HDR : PRE_S_PFX;
            end else begin
               next_st.step = st.step + 1'b1;
            end
         end
         PRE_S_PFX: begin
            if (emit) begin
               next_st.state = PRE_S_HDR;
            end
         end
         PRE_S_HDR: begin
            if (emit) begin
               next_st.cnt = PRE_CNT_RST;
               next_st.state = PRE_S_PAY;
            end
         end
         PRE_S_PAY: begin
            if (emit) begin
               next_st.cnt = st.cnt + 1'b1;
               if (st.cnt == PRE_PAY_LAST) begin
                  next_st.step = st.step + 1'b1;
                  next_st.state = PRE_S_SEL;
               end
            end
         end
         PRE_S_TERM: begin
            if (emit) begin
               next_st.cnt = PRE_CNT_RST;
               next_st.state = st.rec.ts_valid ? PRE_S_TSPAY : PRE_S_PAD;
            end
         end
         PRE_S_TSPAY: begin
            if (emit) begin
               next_st.cnt = st.cnt + 1'b1;
               if (st.cnt == PRE_PAY_LAST) begin
                  next_st.state = PRE_S_PAD;
               end
            end
         end
         PRE_S_PAD: begin
            if (st.pos == '0) begin
               next_st.state = PRE_S_IDLE;
            end
         end
         default: begin
            next_st.state = PRE_S_IDLE;
         end
      endcase
      // Ready only while idle
      next_st.rec_ready = (next_st.state == PRE_S_IDLE);
      // Output register holds a byte until taken
      if (fifo_out_ready) begin
         next_st.out_valid = fifo_out_valid;
         next_st.out_data = fifo_out_data;
      end
   end

   // State register
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state register
   assign rec_ready = st.rec_ready;
   assign out_valid = st.out_valid;
   assign out_data = st.out_data;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   // Packet shapes, record order and output hold

   // Prefix byte taken, header byte follows
   sequence s_pfx_then_hdr;
      (st.state == PRE_S_PFX) && emit ##1 (st.state == PRE_S_HDR);
   endsequence

   // Record opens with a select, then the instruction address header
   sequence s_accept_to_pc;
      (st.state == PRE_S_SEL) && (st.step == PRE_STEP_RST) ##1
         (st.state == PRE_S_HDR) && (cur_idx == PRE_IDX_PC);
   endsequence

   a_hdr_addr_form: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_HDR) && emit |-> (gen_byte[7:3] == 5'b10110))
      else $error("address header byte malformed");

   a_hdr_low_index: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_HDR) && emit |-> (gen_byte[2:0] == cur_idx[2:0]))
      else $error("address header index bits wrong");

   a_pfx_long_idx: assert property (@(posedge ref_clk) disable iff (reset)
      s_pfx_then_hdr |-> (cur_idx[4:3] != 2'h0) && ($past(gen_byte) == {6'h08, cur_idx[4:3]}))
      else $error("prefix byte used or coded wrongly");

   a_short_only_low: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_SEL) && (st.step != PRE_STEP_TERM) && incl[st.step] &&
      (cur_idx[4:3] != 2'h0) |=> (st.state == PRE_S_PFX))
      else $error("short form used for high index");

   a_pc_first_pkt: assert property (@(posedge ref_clk) disable iff (reset)
      accept |=> s_accept_to_pc)
      else $error("record does not open with instruction address");

   a_pay_eight: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_PAY) && emit && (st.cnt == PRE_PAY_LAST) |=> (st.state == PRE_S_SEL))
      else $error("address payload not eight bytes");

   a_term_code: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_TERM) && emit |->
         (gen_byte == (st.rec.ts_valid ? 8'h71 : 8'h01)) ##1
         (st.state == (st.rec.ts_valid ? PRE_S_TSPAY : PRE_S_PAD)))
      else $error("record terminator wrong");

   a_pad_only_zero: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_PAD) && emit |-> (gen_byte == 8'h00))
      else $error("non padding byte between records");

   a_pad_aligned: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_PAD) ##1 (st.state == PRE_S_IDLE) |-> ($past(st.pos) == '0))
      else $error("record left unaligned");

   a_idx_legal: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_HDR) |-> pre_idx_ok(cur_idx))
      else $error("reserved address index generated");

   a_pa_skip_abort: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_HDR) && (cur_idx == PRE_IDX_DPA) |->
         (st.rec.op == PRE_OP_MEM) && st.rec.physical_address_collection_enable &&
         (!st.rec.abort || (st.rec.perm_fault && PA_ON_PERM_FAULT)))
      else $error("physical address packet not allowed");

   a_out_held: assert property (@(posedge ref_clk) disable iff (reset)
      out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output byte dropped or changed");

   a_hdr_to_pay: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_HDR) && emit |=> (st.state == PRE_S_PAY) && (st.cnt == PRE_CNT_RST))
      else $error("header not followed by payload");

   a_term_after_sel: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_SEL) && (st.step == PRE_STEP_TERM) |=> (st.state == PRE_S_TERM))
      else $error("record not closed by terminator");

   a_ts_eight: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_TSPAY) && emit && (st.cnt == PRE_PAY_LAST) |=> (st.state == PRE_S_PAD))
      else $error("timestamp payload not eight bytes");

   a_pc_top_zero: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_PAY) && (st.step == 3'h0) && (st.cnt == PRE_PAY_LAST) |->
         (gen_byte[4:0] == 5'h00))
      else $error("instruction address top byte low bits set");

   a_pa_top_zero: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_PAY) && (cur_idx == PRE_IDX_DPA) && (st.cnt == PRE_PAY_LAST) |->
         (gen_byte[6:0] == 7'h00))
      else $error("physical address top byte low bits set");

   a_idle_no_byte: assert property (@(posedge ref_clk) disable iff (reset)
      (st.state == PRE_S_IDLE) |-> !gen_valid)
      else $error("byte generated outside a record");

   a_rdy_only_idle: assert property (@(posedge ref_clk) disable iff (reset)
      rec_ready |-> (st.state == PRE_S_IDLE))
      else $error("record taken while busy");
endmodule : pre_encoder

// >>> dv/pre_sink.sv
// Purpose: Buffer write model that takes stream bytes from the encoder
// Assumes: Ready changes on the falling edge, bytes taken on the rising edge
// Notes: Slow mode takes every other cycle, hold stalls it completely
`timescale 1ns/100ps
module pre_sink (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Byte stream from the encoder
   input wire logic out_valid,
   input wire logic [7:0] out_data,
   output logic out_ready,
   // Pace controls from the bench
   input wire logic slow,
   input wire logic hold
);
   logic [7:0] got[$];
   logic ph;

   ////////////////////////////////////////////////////////////////////////////////
   // Ready pacing, changed away from the sampling edge
   always @(negedge ref_clk or posedge reset) begin
      if (reset) begin
         out_ready <= 1'b0;
         ph <= 1'b0;
      end else begin
         ph <= !ph;
         out_ready <= !hold && !(slow && ph);
      end
   end

   // Store each accepted byte at the next buffer address
   always @(posedge ref_clk) begin
      if (!reset && out_valid && out_ready) begin
         got.push_back(out_data);
      end
   end
endmodule : pre_sink

// >>> dv/testbench.sv
// Purpose: Self-checking bench for the record packet encoder
// Assumes: Small record alignment of 4 bytes to keep padding short
// Notes: Expected streams built here from the record fields
`timescale 1ns/100ps
module testbench;
   import pre_pkg::*;
   localparam int ALIGN = 4;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic rec_valid = 1'b0;
   pre_rec_t rec = '0;
   logic rec_ready, out_valid, out_ready;
   logic [7:0] out_data;
   logic slow = 1'b0;
   logic hold = 1'b0;
   int n_errors = 0;
   int checks = 0;
   int total = 0;
   int cycles = 0;
   logic [7:0] exp_q[$];

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, design and buffer model
   always #12.5 ref_clk = !ref_clk;
   pre_encoder #(.REC_ALIGN(ALIGN)) uut (.ref_clk(ref_clk), .reset(reset),
      .rec_valid(rec_valid), .rec(rec), .rec_ready(rec_ready), .out_valid(out_valid),
      .out_data(out_data), .out_ready(out_ready));
   pre_sink buf_model (.ref_clk(ref_clk), .reset(reset), .out_valid(out_valid),
      .out_data(out_data), .out_ready(out_ready), .slow(slow), .hold(hold));

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and hang guard
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("Counts: %0d checks, %0d mismatches", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 8000) begin
         n_errors++;
         $display("Error at %0t: run took too long", $time);
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Expected stream builders
   task automatic put_addr(input logic [4:0] idx, input logic [63:0] pay);
      if (idx[4:3] != 2'h0) exp_q.push_back({6'h08, idx[4:3]});
      exp_q.push_back({5'h16, idx[2:0]});
      for (int i = 0; i < 8; i++) exp_q.push_back(pay[8*i+:8]);
   endtask : put_addr

   task automatic send_rec(input pre_rec_t r);
      int k;
      exp_q.delete();
      put_addr(5'h00, {r.pc_security_state_bit, r.pc_privilege_level_field, 5'h00, r.pc});
      if (r.op == PRE_OP_BRANCH || r.op == PRE_OP_ERET)
         put_addr(5'h01, {r.tgt_security_state_bit, r.tgt_privilege_level_field, 5'h00, r.tgt});
      if (r.op == PRE_OP_MEM) begin
         put_addr(5'h02, r.data_va);
         if (r.physical_address_collection_enable && !r.abort)
            put_addr(5'h03, {r.pa_security_state_bit, 7'h00, r.data_pa});
      end
      if (r.impl_valid && (r.impl_idx[4:1] == 4'h3 || r.impl_idx[4])) put_addr(r.impl_idx, r.impl_addr);
      if (r.ts_valid) begin
         exp_q.push_back(8'h71);
         for (int i = 0; i < 8; i++) exp_q.push_back(r.ts[8*i+:8]);
      end else exp_q.push_back(8'h01);
      while ((total + exp_q.size()) % ALIGN != 0) exp_q.push_back(8'h00);
      total += exp_q.size();
      buf_model.got.delete();
      k = 0;
      while (rec_ready !== 1'b1 && k < 200) begin
         @(negedge ref_clk);
         k++;
      end
      rec <= r;
      rec_valid <= 1'b1;
      @(negedge ref_clk);
      rec_valid <= 1'b0;
   endtask : send_rec

   task automatic finish_rec(input string name);
      int k;
      int p;
      logic [7:0] b;
      k = 0;
      while ((buf_model.got.size() < exp_q.size() || rec_ready !== 1'b1) && k < 1500) begin
         @(negedge ref_clk);
         k++;
      end
      check(buf_model.got.size(), exp_q.size(), "stream length");
      for (int i = 0; i < exp_q.size() && i < buf_model.got.size(); i++)
         check(buf_model.got[i], exp_q[i], "stream byte");
      // Walk packets by their size field alone, as a stream reader would
      p = 0;
      while (p < buf_model.got.size()) begin
         b = buf_model.got[p];
         if (b[7:5] == 3'h1) begin
            p++;
            b = buf_model.got[p];
         end
         p += 1 + (((b[7:6] == 2'h2) || (b == 8'h71)) ? (1 << b[5:4]) : 0);
      end
      check(p, buf_model.got.size(), "packet walk end");
      $display("Test %s done", name);
   endtask : finish_rec

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_plain();
      pre_rec_t r = '0;
      r.pc = 56'h123456789abcde;
      r.pc_security_state_bit = 1'b1;
      r.pc_privilege_level_field = 2'h2;
      send_rec(r);
      finish_rec("plain");
      check(buf_model.got[0], 8'hb0, "pc header");
      check(buf_model.got[8], 8'hc0, "pc top byte");
      check(buf_model.got[9], 8'h01, "end header");
   endtask : t_plain

   task automatic t_branch();
      pre_rec_t r = '0;
      r.op = PRE_OP_BRANCH;
      r.pc = 56'h00000000001000;
      r.tgt = 56'h0000000000a5a0;
      r.tgt_privilege_level_field = 2'h3;
      r.ts_valid = 1'b1;
      r.ts = 64'h0102030405060708;
      slow = 1'b1;
      send_rec(r);
      finish_rec("branch slow");
      slow = 1'b0;
      check(buf_model.got[9], 8'hb1, "target header");
      check(buf_model.got[17], 8'h60, "target top byte");
      check(buf_model.got[18], 8'h71, "timestamp header");
      check(buf_model.got[19], 8'h08, "timestamp low byte");
   endtask : t_branch

   task automatic t_mem();
      pre_rec_t r = '0;
      r.op = PRE_OP_MEM;
      r.data_va = 64'hfedcba9876543210;
      r.data_pa = 56'h00000012345678;
      r.pa_security_state_bit = 1'b1;
      r.physical_address_collection_enable = 1'b1;
      r.impl_valid = 1'b1;
      r.impl_idx = 5'h12;
      r.impl_addr = 64'h5555aaaa5555aaaa;
      send_rec(r);
      finish_rec("memory");
      check(buf_model.got[9], 8'hb2, "data va header");
      check(buf_model.got[18], 8'hb3, "pa header");
      check(buf_model.got[26], 8'h80, "pa top byte");
      check(buf_model.got[27], 8'h22, "prefix byte");
      check(buf_model.got[28], 8'hb2, "extended header");
   endtask : t_mem

   task automatic t_drop();
      pre_rec_t r = '0;
      r.op = PRE_OP_MEM;
      r.abort = 1'b1;
      r.physical_address_collection_enable = 1'b1;
      r.impl_valid = 1'b1;
      r.impl_idx = 5'h04;
      send_rec(r);
      finish_rec("abort reserved");
      check(buf_model.got[18], 8'h01, "no pa no reserved");
      r.abort = 1'b0;
      r.physical_address_collection_enable = 1'b0;
      r.impl_idx = 5'h07;
      send_rec(r);
      finish_rec("collect off short");
      check(buf_model.got[18], 8'hb7, "short impl header");
   endtask : t_drop

   task automatic t_stall();
      pre_rec_t r = '0;
      logic [7:0] d;
      r.op = PRE_OP_ERET;
      r.tgt_profiling_off = 1'b1;
      r.tgt_security_state_bit = 1'b1;
      hold = 1'b1;
      send_rec(r);
      repeat (20) @(negedge ref_clk);
      d = out_data;
      check(out_valid, 1'b1, "byte offered in stall");
      check(rec_ready, 1'b0, "busy while full");
      repeat (5) @(negedge ref_clk);
      check(out_data, d, "byte held in stall");
      hold = 1'b0;
      finish_rec("eret stall");
      check(buf_model.got[9], 8'hb1, "eret target");
   endtask : t_stall

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      reset = 1'b0;
      t_plain();
      t_branch();
      t_mem();
      t_drop();
      t_stall();
      end_sim();
   end
endmodule : testbench
